// ---- rtl/dpb_pkg.sv ----
// Constants, types and timing for the dual-port RAM port controller.
// Assumes one 100 MHz clock and a single port of the RAM bank on the pins.
//
// Operation
// RULE1: Device lets one access win, flags other.
// RULE2: Device blocks writes from the flagged port.
// RULE3: Select high means master, low slave.
// RULE4: Slave conflict pin only inhibits that port.
// RULE5: Hold slave inhibit high; low blocks writes.
// RULE6: AND conflict flags of depth-stacked devices.
// RULE7: Exactly one master per width group.
// RULE8: Master arbitrates on select and address only.
// RULE9: Hold address until conflict settles, then write.
// RULE10: Eight semaphore latches, separate from array.
// RULE11: Ports never slow each other.
// RULE12: Both selects inactive puts port in standby.
// RULE13: Flags gate nothing in hardware.
// RULE14: Semaphore accesses never wait.
// RULE15: Simultaneous semaphore requests resolve cleanly.
// RULE16: Write request, then read back to confirm.
// RULE17: Write zero requests, write one releases.
// RULE18: Semaphore write uses bit zero; read replicates.
// RULE19: Semaphore chosen by three lowest address bits.
// RULE20: Pending request wins once holder releases.
package dpb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 18;
  localparam int FLAG_IDX_W = 3;
  localparam int BANK_N     = 2;   // Devices stacked in depth
  localparam int SYNC_N     = 2;   // Synchroniser stages on pins

  // ----------------------------------------------------------------
  // Timing, times in ns and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_NS           = 10;
  localparam int T_BUSY_SETTLE_NS = 20;
  localparam int T_WR_PULSE_NS    = 15;
  localparam int T_RD_ACCESS_NS   = 15;
  localparam int T_RECOVER_NS     = 10;

  localparam logic [3:0] SETTLE_CYC  = 4'((T_BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS + SYNC_N);
  localparam logic [3:0] WR_CYC      = 4'((T_WR_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RD_CYC      = 4'((T_RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_N);
  localparam logic [3:0] REC_CYC     = 4'((T_RECOVER_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // Reset values of pins
  // ----------------------------------------------------------------
  localparam logic RST_MS_SEL      = 1'b1;  // This bank acts as master
  localparam logic RST_INHIBIT_N   = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_MEM_RD   = 3'h0,
    OP_MEM_WR   = 3'h1,
    OP_SEM_TAKE = 3'h2,
    OP_SEM_GIVE = 3'h3,
    OP_SEM_TEST = 3'h4
  } dpb_op_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_SETUP   = 3'h1,
    ST_WRITE   = 3'h2,
    ST_READ    = 3'h3,
    ST_RECOVER = 3'h4
  } dpb_state_t;

  typedef struct packed {
    dpb_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } dpb_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0]   rdata;
    logic                granted;    // Token held after take or test
    logic                busy_seen;  // Access stalled on conflict
  } dpb_rsp_t;

  // Semaphore space decode, used by several drivers
  function automatic logic is_sem(input dpb_op_t op);
    is_sem = (op == OP_SEM_TAKE) || (op == OP_SEM_GIVE) || (op == OP_SEM_TEST);
  endfunction : is_sem

  function automatic logic is_write(input dpb_op_t op);
    is_write = (op == OP_MEM_WR) || (op == OP_SEM_TAKE) || (op == OP_SEM_GIVE);
  endfunction : is_write

endpackage : dpb_pkg

// ---- rtl/dpb_port_ctrl.sv ----
// Host-side controller for one port of a dual-port RAM bank.
// Assumes the RAM pins are asynchronous to SYS_CLK; conflict and data
// inputs are synchronised before use. The bank's other port belongs to
// another processor.
`timescale 1ns/1ps
module dpb_port_ctrl (
  input  wire logic                        SYS_CLK,
  input  wire logic                        RST_N,
  input  wire logic                        CMD_VALID,
  input  wire dpb_pkg::dpb_cmd_t           CMD,
  output logic                             CMD_READY,
  output logic                             RSP_VALID,
  output dpb_pkg::dpb_rsp_t                RSP,
  input  wire logic                        BLOCK_WRITES,
  output logic                             RAM_MS_SEL,
  output logic                             RAM_INHIBIT_N,
  output logic                             RAM_CE_N,
  output logic                             RAM_SEM_N,
  output logic                             RAM_RW_N,
  output logic                             RAM_OE_N,
  output logic [dpb_pkg::ADDR_W-1:0]       RAM_ADDR,
  output logic [dpb_pkg::DATA_W-1:0]       RAM_DQ_O,
  output logic                             RAM_DQ_OE_N,
  input  wire logic [dpb_pkg::DATA_W-1:0]  RAM_DQ_I,
  input  wire logic [dpb_pkg::BANK_N-1:0]  RAM_BUSY_N
);
  import dpb_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  dpb_state_t          state_reg,   state_next;
  logic [3:0]          cnt_reg,     cnt_next;
  dpb_cmd_t            cmd_reg,     cmd_next;
  logic                rdback_reg,  rdback_next;
  logic                ce_n_reg,    ce_n_next;
  logic                sem_n_reg,   sem_n_next;
  logic                rw_n_reg,    rw_n_next;
  logic                oe_n_reg,    oe_n_next;
  logic                dq_oe_n_reg, dq_oe_n_next;
  logic [ADDR_W-1:0]   addr_reg,    addr_next;
  logic [DATA_W-1:0]   dq_o_reg,    dq_o_next;
  logic                ready_reg;
  logic                rsp_v_reg,   rsp_v_next;
  dpb_rsp_t            rsp_reg,     rsp_next;
  logic                ms_reg;
  logic                inhibit_n_reg;
  logic [DATA_W-1:0]   dq_s1_reg,   dq_s2_reg;
  logic [BANK_N-1:0]   busy_s1_reg, busy_s2_reg;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire logic              accept    = CMD_VALID && ready_reg && (state_reg == ST_IDLE);
  wire logic              cnt_done  = (cnt_reg == 4'h0);
  wire logic              bank_busy = ~(&busy_s2_reg);          // RULE6
  wire logic              cur_sem   = is_sem(cmd_reg.op);
  wire logic              cur_wr    = is_write(cmd_reg.op) && !rdback_reg;
  wire logic              sem_val   = (cmd_reg.op == OP_SEM_GIVE); // RULE17
  wire logic [DATA_W-1:0] wr_word   = cur_sem ? {DATA_W{sem_val}} : cmd_reg.wdata;
  wire logic [ADDR_W-1:0] cmd_addr  = is_sem(CMD.op) ?
                                      {{(ADDR_W-FLAG_IDX_W){1'b0}}, CMD.addr[FLAG_IDX_W-1:0]} :
                                      CMD.addr;
  wire logic [ADDR_W-1:0] sem_addr  = {{(ADDR_W-FLAG_IDX_W){1'b0}}, cmd_reg.addr[FLAG_IDX_W-1:0]};

  // ------------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------------
  // One port cycle: select, let arbitration settle, then pulse strobe
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    cmd_next     = cmd_reg;
    rdback_next  = rdback_reg;
    ce_n_next    = ce_n_reg;
    sem_n_next   = sem_n_reg;
    rw_n_next    = rw_n_reg;
    oe_n_next    = oe_n_reg;
    dq_oe_n_next = dq_oe_n_reg;
    addr_next    = addr_reg;
    dq_o_next    = dq_o_reg;
    rsp_v_next   = 1'b0;
    rsp_next     = rsp_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          cmd_next           = CMD;
          rdback_next        = 1'b0;
          addr_next          = cmd_addr;                        // RULE19
          ce_n_next          = is_sem(CMD.op);
          sem_n_next         = ~is_sem(CMD.op);
          cnt_next           = SETTLE_CYC;                      // RULE9
          rsp_next.busy_seen = 1'b0;
          state_next         = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (!cnt_done) begin
          cnt_next = cnt_reg - 4'h1;
        end else if (!cur_sem && bank_busy) begin
          rsp_next.busy_seen = 1'b1;                            // RULE9
        end else if (cur_wr) begin
          // Semaphore path never waits on conflict               RULE14
          rw_n_next    = 1'b0;
          dq_oe_n_next = 1'b0;
          dq_o_next    = wr_word;                               // RULE18
          cnt_next     = WR_CYC;
          state_next   = ST_WRITE;
        end else begin
          oe_n_next  = 1'b0;
          cnt_next   = RD_CYC;
          state_next = ST_READ;
        end
      end
      ST_WRITE: begin
        if (!cnt_done) begin
          cnt_next = cnt_reg - 4'h1;
        end else begin
          rw_n_next    = 1'b1;
          dq_oe_n_next = 1'b1;
          ce_n_next    = 1'b1;
          sem_n_next   = 1'b1;
          cnt_next     = REC_CYC;
          state_next   = ST_RECOVER;
          if (cmd_reg.op == OP_SEM_TAKE) begin
            rdback_next = 1'b1;                                 // RULE16
          end else begin
            rsp_v_next       = 1'b1;
            rsp_next.rdata   = cmd_reg.wdata;
            rsp_next.granted = 1'b0;
          end
        end
      end
      ST_READ: begin
        if (!cnt_done) begin
          cnt_next = cnt_reg - 4'h1;
        end else begin
          // Deselect so the device's read latch refreshes next time
          oe_n_next        = 1'b1;
          ce_n_next        = 1'b1;
          sem_n_next       = 1'b1;
          rdback_next      = 1'b0;
          rsp_v_next       = 1'b1;
          rsp_next.rdata   = dq_s2_reg;
          rsp_next.granted = cur_sem && !dq_s2_reg[0];          // RULE17
          cnt_next         = REC_CYC;
          state_next       = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (!cnt_done) begin
          cnt_next = cnt_reg - 4'h1;
        end else if (rdback_reg) begin
          sem_n_next = 1'b0;                                    // RULE16
          addr_next  = sem_addr;
          cnt_next   = SETTLE_CYC;
          state_next = ST_SETUP;
        end else begin
          state_next = ST_IDLE;                                 // RULE12
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Pins are asynchronous; second stage is the only reader of the first
  always_ff @(posedge SYS_CLK) begin
    dq_s1_reg   <= RAM_DQ_I;
    dq_s2_reg   <= dq_s1_reg;
    busy_s1_reg <= RAM_BUSY_N;
    busy_s2_reg <= busy_s1_reg;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Sequencer state and pin drivers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 4'h0;
      cmd_reg     <= '0;
      rdback_reg  <= 1'b0;
      ce_n_reg    <= 1'b1;
      sem_n_reg   <= 1'b1;
      rw_n_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
      dq_oe_n_reg <= 1'b1;
      addr_reg    <= '0;
      dq_o_reg    <= '0;
      ready_reg   <= 1'b0;
      rsp_v_reg   <= 1'b0;
      rsp_reg     <= '0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      cmd_reg     <= cmd_next;
      rdback_reg  <= rdback_next;
      ce_n_reg    <= ce_n_next;
      sem_n_reg   <= sem_n_next;
      rw_n_reg    <= rw_n_next;
      oe_n_reg    <= oe_n_next;
      dq_oe_n_reg <= dq_oe_n_next;
      addr_reg    <= addr_next;
      dq_o_reg    <= dq_o_next;
      ready_reg   <= (state_next == ST_IDLE) && !accept;
      rsp_v_reg   <= rsp_v_next;
      rsp_reg     <= rsp_next;
    end
  end

  // Bank strapping: one master per width group, inhibit on demand
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ms_reg        <= RST_MS_SEL;                              // RULE7
      inhibit_n_reg <= RST_INHIBIT_N;
    end else begin
      ms_reg        <= RST_MS_SEL;
      inhibit_n_reg <= !BLOCK_WRITES;                           // RULE5
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign CMD_READY     = ready_reg;
  assign RSP_VALID     = rsp_v_reg;
  assign RSP           = rsp_reg;
  assign RAM_MS_SEL    = ms_reg;
  assign RAM_INHIBIT_N = inhibit_n_reg;
  assign RAM_CE_N      = ce_n_reg;
  assign RAM_SEM_N     = sem_n_reg;
  assign RAM_RW_N      = rw_n_reg;
  assign RAM_OE_N      = oe_n_reg;
  assign RAM_ADDR      = addr_reg;
  assign RAM_DQ_O      = dq_o_reg;
  assign RAM_DQ_OE_N   = dq_oe_n_reg;

endmodule : dpb_port_ctrl

// ---- tb/dpb_port_ctrl_assertions.sv ----
// Pin-level checks for the port controller.
// Assumes it is bound to dpb_port_ctrl; one clock domain.
`timescale 1ns/1ps
module dpb_port_ctrl_assertions
  import dpb_pkg::*;
(
  input wire logic                       SYS_CLK,
  input wire logic                       RST_N,
  input wire logic                       CMD_VALID,
  input wire dpb_pkg::dpb_cmd_t          CMD,
  input wire logic                       CMD_READY,
  input wire logic                       BLOCK_WRITES,
  input wire logic                       RAM_MS_SEL,
  input wire logic                       RAM_INHIBIT_N,
  input wire logic                       RAM_CE_N,
  input wire logic                       RAM_SEM_N,
  input wire logic                       RAM_RW_N,
  input wire logic                       RAM_OE_N,
  input wire logic [dpb_pkg::ADDR_W-1:0] RAM_ADDR,
  input wire logic [dpb_pkg::DATA_W-1:0] RAM_DQ_O,
  input wire logic                       RAM_DQ_OE_N,
  input wire logic [dpb_pkg::BANK_N-1:0] RAM_BUSY_N
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire logic take_w = CMD_VALID && CMD_READY;

  master_strap_a: assert property (RAM_MS_SEL) else $error("strap not master");
  inhibit_set_a: assert property (BLOCK_WRITES |=> !RAM_INHIBIT_N) else $error("inhibit not driven");
  inhibit_free_a: assert property (!BLOCK_WRITES |=> RAM_INHIBIT_N) else $error("inhibit stuck");
  write_setup_a: assert property ($fell(RAM_RW_N) |-> $past(RAM_ADDR, 4) == RAM_ADDR
    && !($past(RAM_CE_N, 4) && $past(RAM_SEM_N, 4))) else $error("write before settle");
  busy_stall_a: assert property ($fell(RAM_RW_N) && !RAM_CE_N |-> (&$past(RAM_BUSY_N, 1))
    || (&$past(RAM_BUSY_N, 2)) || (&$past(RAM_BUSY_N, 3)) || (&$past(RAM_BUSY_N, 4)))
    else $error("write during conflict");
  sem_index_a: assert property (!RAM_SEM_N |-> RAM_ADDR[ADDR_W-1:3] == '0) else $error("sem addr");
  sem_spread_a: assert property (!RAM_SEM_N && !RAM_DQ_OE_N
    |-> RAM_DQ_O == {DATA_W{RAM_DQ_O[0]}}) else $error("sem data not spread");
  take_zero_a: assert property (take_w && CMD.op == OP_SEM_TAKE
    |-> ##[2:12] (!RAM_SEM_N && !RAM_RW_N && !RAM_DQ_O[0])) else $error("take without zero");
  give_one_a: assert property (take_w && CMD.op == OP_SEM_GIVE
    |-> ##[2:12] (!RAM_SEM_N && !RAM_RW_N && RAM_DQ_O[0])) else $error("give without one");
  take_check_a: assert property (take_w && CMD.op == OP_SEM_TAKE
    |-> ##[12:40] (!RAM_SEM_N && RAM_RW_N && !RAM_OE_N)) else $error("take not read back");
  idle_standby_a: assert property (CMD_READY |-> RAM_CE_N && RAM_SEM_N) else $error("idle selected");

  // Main scenarios reached
  cover property (take_w && CMD.op == OP_SEM_TAKE);
  cover property (!RAM_CE_N && !(&RAM_BUSY_N));
  cover property (BLOCK_WRITES ##1 !RAM_INHIBIT_N);
endmodule : dpb_port_ctrl_assertions

bind dpb_port_ctrl dpb_port_ctrl_assertions dpb_port_ctrl_assertions_inst (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
  .BLOCK_WRITES(BLOCK_WRITES), .RAM_MS_SEL(RAM_MS_SEL), .RAM_INHIBIT_N(RAM_INHIBIT_N),
  .RAM_CE_N(RAM_CE_N), .RAM_SEM_N(RAM_SEM_N), .RAM_RW_N(RAM_RW_N), .RAM_OE_N(RAM_OE_N),
  .RAM_ADDR(RAM_ADDR), .RAM_DQ_O(RAM_DQ_O), .RAM_DQ_OE_N(RAM_DQ_OE_N), .RAM_BUSY_N(RAM_BUSY_N));

// ---- tb/dpb_ram_model.sv ----
// One port of the dual-port RAM bank with its semaphore latches.
// Assumes the far port is played by the bench through the oth_ inputs.
`timescale 1ns/1ps
module dpb_ram_model
  import dpb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              ms_sel,
  input  wire logic              ce_n,
  input  wire logic              sem_n,
  input  wire logic              rw_n,
  input  wire logic              oe_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_o,
  input  wire logic              oth_ce_n,
  input  wire logic [ADDR_W-1:0] oth_addr,
  input  wire logic              oth_sem_we,
  input  wire logic [2:0]        oth_sem_idx,
  input  wire logic              oth_sem_d,
  output logic [DATA_W-1:0]      dq_i,
  output logic                   busy_n
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];     // Memory array
  logic [7:0]        req_a = '1;                // Request latches, this port
  logic [7:0]        req_b = '1;
  logic [7:0]        own_a = '0;
  logic [7:0]        own_b = '0;
  logic [DATA_W-1:0] last = '0;

  // Far port got there first, so this port is flagged; a slave flags nothing
  assign busy_n = !(ms_sel && !ce_n && !oth_ce_n && addr == oth_addr);

  // Latches resolve every edge; this port wins a tie, a pending request inherits
  always @(posedge clk) begin
    if (!sem_n && !rw_n) req_a[addr[2:0]] = dq_o[0];
    if (oth_sem_we) req_b[oth_sem_idx] = oth_sem_d;
    for (int i = 0; i < 8; i++) begin
      if (req_a[i]) own_a[i] = 1'b0;
      if (req_b[i]) own_b[i] = 1'b0;
      if (!own_a[i] && !own_b[i]) begin
        own_a[i] = !req_a[i];
        own_b[i] = req_a[i] && !req_b[i];
      end
    end
    if (!ce_n && !rw_n && busy_n) mem[addr] = dq_o;
    last <= dq_i;
  end

  // Unselected bus toggles between the complement of the last driven word and that word
  always_comb begin
    if (!sem_n && !oe_n && rw_n) dq_i = {DATA_W{!own_a[addr[2:0]]}};
    else if (!ce_n && !oe_n && rw_n) dq_i = mem[addr];
    else dq_i = ~last;
  end
endmodule : dpb_ram_model

// ---- tb/dpb_port_ctrl_test.sv ----
// Self-checking bench for the port controller.
// Assumes the RAM model stands on the pins; the bench plays the far port.
`timescale 1ns/1ps
module dpb_port_ctrl_test;
  import dpb_pkg::*;
  logic sys_clk = 0, rst_n = 0, cmd_valid = 0, cmd_ready, rsp_valid, block_writes = 0;
  logic ms_sel, inhibit_n, ce_n, sem_n, rw_n, oe_n, dq_oe_n, busy0_n, busy1_n = 1;
  logic oth_ce_n = 1, oth_sem_we = 0, oth_sem_d = 1;
  logic [2:0] oth_sem_idx = '0;
  logic [ADDR_W-1:0] addr, oth_addr = '0;
  logic [DATA_W-1:0] dq_o, dq_i;
  dpb_cmd_t cmd = '0;
  dpb_rsp_t rsp, got;
  int mismatches = 0, cmd_count = 0, cmp_count = 0;

  dpb_port_ctrl dpb_port_ctrl_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD(cmd),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP(rsp), .BLOCK_WRITES(block_writes),
    .RAM_MS_SEL(ms_sel), .RAM_INHIBIT_N(inhibit_n), .RAM_CE_N(ce_n), .RAM_SEM_N(sem_n), .RAM_RW_N(rw_n),
    .RAM_OE_N(oe_n), .RAM_ADDR(addr), .RAM_DQ_O(dq_o), .RAM_DQ_OE_N(dq_oe_n), .RAM_DQ_I(dq_i),
    .RAM_BUSY_N({busy1_n, busy0_n}));
  dpb_ram_model dpb_ram_model_inst (.clk(sys_clk), .ce_n(ce_n), .sem_n(sem_n), .rw_n(rw_n), .oe_n(oe_n),
    .ms_sel(ms_sel), .addr(addr), .dq_o(dq_o), .oth_ce_n(oth_ce_n), .oth_addr(oth_addr), .oth_sem_we(oth_sem_we),
    .oth_sem_idx(oth_sem_idx), .oth_sem_d(oth_sem_d), .dq_i(dq_i), .busy_n(busy0_n));

  initial forever #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Drivers and comparisons
  // ----------------------------------------------------------------
  task automatic run(input dpb_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    cmd <= '{op: op, addr: a, wdata: d};
    cmd_valid <= 1'b1;
    do @(negedge sys_clk); while (cmd_ready !== 1'b1);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 300 && rsp_valid !== 1'b1; i++) @(negedge sys_clk);
    chk_bit(rsp_valid, 1'b1);
    got = rsp;
    cmd_count++;
  endtask : run

  task automatic chk_word(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic e);
    chk_word({17'h0, g}, {17'h0, e});
  endtask : chk_bit

  // Far port writes one semaphore request latch
  task automatic oth_sem(input logic [2:0] i, input logic d);
    @(posedge sys_clk);
    oth_sem_we <= 1'b1;
    oth_sem_idx <= i;
    oth_sem_d <= d;
    @(posedge sys_clk);
    oth_sem_we <= 1'b0;
  endtask : oth_sem

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_conflict;
    run(OP_MEM_WR, 15'h7fff, 18'h2a5a5);
    chk_bit(got.busy_seen, 1'b0);
    @(posedge sys_clk);
    oth_addr <= 15'h0042;
    oth_ce_n <= 1'b0;
    fork
      run(OP_MEM_WR, 15'h0042, 18'h13579);
      begin repeat (40) @(posedge sys_clk); oth_ce_n <= 1'b1; end
    join
    chk_bit(got.busy_seen, 1'b1);
    run(OP_MEM_RD, 15'h0042, 18'h0);
    chk_word(got.rdata, 18'h13579);
    @(posedge sys_clk);
    busy1_n <= 1'b0;
    fork
      run(OP_MEM_RD, 15'h7fff, 18'h0);
      begin repeat (30) @(posedge sys_clk); busy1_n <= 1'b1; end
    join
    chk_bit(got.busy_seen, 1'b1);
    chk_word(got.rdata, 18'h2a5a5);
  endtask : t_conflict

  task automatic t_sem;
    for (int i = 0; i < 8; i++) begin
      run(OP_SEM_TAKE, {12'hfff, 3'(i)}, 18'h0);
      chk_bit(got.granted, 1'b1);
      chk_word(got.rdata, 18'h0);
    end
    for (int i = 0; i < 8; i++) run(OP_SEM_GIVE, 15'(i), 18'h3ffff);
    run(OP_SEM_TAKE, 15'h7ffd, 18'h0);
    chk_bit(got.granted, 1'b1);
    oth_sem(3'h5, 1'b0);
    run(OP_SEM_TEST, 15'h0005, 18'h0);
    chk_bit(got.granted, 1'b1);
    run(OP_SEM_GIVE, 15'h0005, 18'h3ffff);
    run(OP_SEM_TAKE, 15'h0005, 18'h0);
    chk_bit(got.granted, 1'b0);
    chk_word(got.rdata, 18'h3ffff);
    oth_sem(3'h5, 1'b1);
    run(OP_SEM_TEST, 15'h0005, 18'h0);
    chk_bit(got.granted, 1'b1);
    run(OP_SEM_GIVE, 15'h0005, 18'h3ffff);
    chk_bit(got.granted, 1'b0);
  endtask : t_sem

  task automatic t_inhibit;
    @(posedge sys_clk) block_writes <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_bit(inhibit_n, 1'b0);
    chk_bit(ms_sel, 1'b1);
    @(posedge sys_clk) block_writes <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_bit(inhibit_n, 1'b1);
  endtask : t_inhibit

  task automatic report_and_stop;
    $display("commands %0d, comparisons %0d, mismatches %0d", cmd_count, cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_inhibit();
    t_conflict();
    t_sem();
    report_and_stop();
  end
endmodule : dpb_port_ctrl_test
